// *** rtl/pin_select_pkg.sv ***
package pin_select_pkg;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] FIRST_ALT_FUNCTION_SELECT_OFS = 8'h08;
    localparam logic [7:0] SECOND_ALT_FUNCTION_SELECT_OFS = 8'h0C;
    localparam logic [7:0] THIRD_ALT_FUNCTION_SELECT_OFS = 8'h10;
    localparam logic [7:0] FOURTH_ALT_FUNCTION_SELECT_OFS = 8'h14;
    localparam logic [7:0] OPEN_DRAIN_SELECT_OFS = 8'h28;
    localparam logic [7:0] PULL_UP_SELECT_OFS = 8'h2C;

    // ************************************************************
    // fields and reset values
    // ************************************************************
    localparam int PIN_COUNT = 3;
    localparam int PIN_TWO = 2;
    localparam int PIN_ONE = 1;
    localparam int PIN_ZERO = 0;
    localparam logic [2:0] PIN_FIELD_MASK = 3'h7;
    localparam logic [2:0] FOURTH_FIELD_MASK = 3'h4;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ************************************************************
    // idle levels seen by peripherals whose pin is not routed
    // ************************************************************
    localparam logic RECEIVE_IDLE = 1'h1;
    localparam logic CLOCK_IN_IDLE = 1'h1;
    localparam logic CAPTURE_IDLE = 1'h0;
    localparam logic CLEAR_TO_SEND_IDLE = 1'h1;

    typedef logic [2:0] pin_vec_t;

endpackage

// *** rtl/pin_cfg_if.sv ***
// selection bits handed from the register file to the pin router
interface pin_cfg_if;
    import pin_select_pkg::*;
    pin_vec_t first_sel;  // serial one functions
    pin_vec_t second_sel; // bus address lines
    pin_vec_t third_sel;  // timer functions
    pin_vec_t fourth_sel; // flow control
    pin_vec_t open_drain; // driver type
    pin_vec_t pull_up;    // pull-up enables
    modport regs (output first_sel, second_sel, third_sel, fourth_sel, open_drain, pull_up);
    modport route (input first_sel, second_sel, third_sel, fourth_sel, open_drain, pull_up);
endinterface

// *** rtl/pin_route.sv ***
module pin_route
    import pin_select_pkg::*;
(
    pin_cfg_if.route cfg,
    input wire logic [2:0] i_port_data,
    input wire logic [2:0] i_port_oe,
    input wire logic i_transmit,
    input wire logic i_clock_out,
    input wire logic i_clock_oe,
    input wire logic [2:0] i_bus_address,
    input wire logic i_timer_out,
    input wire logic [2:0] i_pin_sync,
    output logic [2:0] o_pin,
    output logic [2:0] o_pin_oe,
    output logic o_receive,
    output logic o_clock_in,
    output logic o_capture_a,
    output logic o_capture_b,
    output logic o_clear_to_send
);

    // ************************************************************
    // driver shaping
    // ************************************************************
    // open drain only pulls low; a high value releases the pin
    function automatic logic [1:0] shape_drive(input logic val, input logic en,
                                               input logic od);
        shape_drive = od ? {1'b0, en & ~val} : {val, en};
    endfunction

    // ************************************************************
    // per-pin function mux
    // ************************************************************
    // functions are checked first to fourth; software must not set two
    always_comb
    begin
        logic [2:0] val;
        logic [2:0] en;
        logic [1:0] drv;
        val = i_port_data;
        en = i_port_oe;
        drv = 2'h0;
        // pin 2: serial clock, address 0, timer out, clear to send
        if (cfg.first_sel[PIN_TWO])
        begin
            val[PIN_TWO] = i_clock_out;
            en[PIN_TWO] = i_clock_oe;
        end
        else if (cfg.second_sel[PIN_TWO])
        begin
            val[PIN_TWO] = i_bus_address[0];
            en[PIN_TWO] = 1'b1;
        end
        else if (cfg.third_sel[PIN_TWO])
        begin
            val[PIN_TWO] = i_timer_out;
            en[PIN_TWO] = 1'b1;
        end
        else if (cfg.fourth_sel[PIN_TWO])
        begin
            en[PIN_TWO] = 1'b0;
        end
        // pin 1: receive, address 1, capture b
        if (cfg.first_sel[PIN_ONE])
        begin
            en[PIN_ONE] = 1'b0;
        end
        else if (cfg.second_sel[PIN_ONE])
        begin
            val[PIN_ONE] = i_bus_address[1];
            en[PIN_ONE] = 1'b1;
        end
        else if (cfg.third_sel[PIN_ONE])
        begin
            en[PIN_ONE] = 1'b0;
        end
        // pin 0: transmit, address 2, capture a
        if (cfg.first_sel[PIN_ZERO])
        begin
            val[PIN_ZERO] = i_transmit;
            en[PIN_ZERO] = 1'b1;
        end
        else if (cfg.second_sel[PIN_ZERO])
        begin
            val[PIN_ZERO] = i_bus_address[2];
            en[PIN_ZERO] = 1'b1;
        end
        else if (cfg.third_sel[PIN_ZERO])
        begin
            en[PIN_ZERO] = 1'b0;
        end
        // driver type per pin
        for (int p = 0; p < PIN_COUNT; p++)
        begin
            drv = shape_drive(val[p], en[p], cfg.open_drain[p]);
            o_pin[p] = drv[1];
            o_pin_oe[p] = drv[0];
        end
    end

    // ************************************************************
    // inputs handed to peripherals
    // ************************************************************
    always_comb
    begin
        o_clock_in = cfg.first_sel[PIN_TWO] ? i_pin_sync[PIN_TWO] : CLOCK_IN_IDLE;
        o_receive = cfg.first_sel[PIN_ONE] ? i_pin_sync[PIN_ONE] : RECEIVE_IDLE;
        o_capture_b = cfg.third_sel[PIN_ONE] ? i_pin_sync[PIN_ONE] : CAPTURE_IDLE;
        o_capture_a = cfg.third_sel[PIN_ZERO] ? i_pin_sync[PIN_ZERO] : CAPTURE_IDLE;
        o_clear_to_send = cfg.fourth_sel[PIN_TWO] ? i_pin_sync[PIN_TWO]
                                                  : CLEAR_TO_SEND_IDLE;
    end

endmodule

// *** rtl/pin_function_select.sv ***
// Operation
// - second select routes pins to address lines
// - third select routes timer output and captures
// - fourth select bit 2 only, clear-to-send
// - open-drain bit chooses driver type per pin
// - first select routes serial clock, receive, transmit
// - pull-up bit enables internal pull-up
//
// Design decisions made here: the address map and the Avalon-MM register port.
module pin_function_select
    import pin_select_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic [2:0] I_PORT_DATA,
    input wire logic [2:0] I_PORT_OE,
    input wire logic I_SERIAL_ONE_TRANSMIT,
    input wire logic I_SERIAL_ONE_CLOCK,
    input wire logic I_SERIAL_ONE_CLOCK_OE,
    input wire logic [2:0] I_BUS_ADDRESS,
    input wire logic I_TIMER_ZERO_OUTPUT,
    input wire logic [2:0] I_PIN,
    output logic [2:0] O_PIN,
    output logic [2:0] O_PIN_OE,
    output logic [2:0] O_PULL_UP,
    output logic [2:0] O_PORT_IN,
    output logic O_SERIAL_ONE_RECEIVE,
    output logic O_SERIAL_ONE_CLOCK_IN,
    output logic O_TIMER_TWO_CAPTURE_IN_A,
    output logic O_TIMER_TWO_CAPTURE_IN_B,
    output logic O_SERIAL_ONE_CLEAR_TO_SEND
);

    // ************************************************************
    // state
    // ************************************************************
    pin_vec_t first_sel, next_first_sel;   // serial one routing
    pin_vec_t second_sel, next_second_sel; // address routing
    pin_vec_t third_sel, next_third_sel;   // timer routing
    pin_vec_t fourth_sel, next_fourth_sel; // flow control routing
    pin_vec_t open_drain, next_open_drain; // driver type
    pin_vec_t pull_up, next_pull_up;       // pull-up enables
    logic waitreq, next_waitreq;           // bus stall flag
    logic [31:0] rdata, next_rdata;        // read answer
    logic [2:0] pin_meta, pin_sync;        // pin synchroniser
    logic [2:0] route_pin, route_oe;       // router outputs
    logic route_rx, route_clk, route_cap_a, route_cap_b, route_cts;
    logic wr_take;                         // write accepted this edge

    pin_cfg_if cfg ();

    // ************************************************************
    // read decode
    // ************************************************************
    // unmapped offsets read as zero
    function automatic logic [31:0] read_mux(input logic [7:0] addr);
        case (addr)
            FIRST_ALT_FUNCTION_SELECT_OFS: read_mux = {29'h0, first_sel};
            SECOND_ALT_FUNCTION_SELECT_OFS: read_mux = {29'h0, second_sel};
            THIRD_ALT_FUNCTION_SELECT_OFS: read_mux = {29'h0, third_sel};
            FOURTH_ALT_FUNCTION_SELECT_OFS: read_mux = {29'h0, fourth_sel};
            OPEN_DRAIN_SELECT_OFS: read_mux = {29'h0, open_drain};
            PULL_UP_SELECT_OFS: read_mux = {29'h0, pull_up};
            default: read_mux = READ_ZERO;
        endcase
    endfunction

    // ************************************************************
    // bus handshake and register writes
    // ************************************************************
    // one stall cycle per request; write lands at the edge waitreq is low
    always_comb
    begin
        wr_take = I_AVS_WRITE & ~waitreq & I_AVS_BYTEENABLE[0];
        next_waitreq = ~((I_AVS_READ | I_AVS_WRITE) & waitreq);
        next_rdata = (I_AVS_READ & waitreq) ? read_mux(I_AVS_ADDRESS) : READ_ZERO;
        next_first_sel = first_sel;
        next_second_sel = second_sel;
        next_third_sel = third_sel;
        next_fourth_sel = fourth_sel;
        next_open_drain = open_drain;
        next_pull_up = pull_up;
        if (wr_take)
        begin
            case (I_AVS_ADDRESS)
                FIRST_ALT_FUNCTION_SELECT_OFS: next_first_sel = I_AVS_WRITEDATA[2:0];
                SECOND_ALT_FUNCTION_SELECT_OFS: next_second_sel = I_AVS_WRITEDATA[2:0];
                THIRD_ALT_FUNCTION_SELECT_OFS: next_third_sel = I_AVS_WRITEDATA[2:0];
                FOURTH_ALT_FUNCTION_SELECT_OFS:
                    next_fourth_sel = I_AVS_WRITEDATA[2:0] & FOURTH_FIELD_MASK;
                OPEN_DRAIN_SELECT_OFS: next_open_drain = I_AVS_WRITEDATA[2:0];
                PULL_UP_SELECT_OFS: next_pull_up = I_AVS_WRITEDATA[2:0];
                default: next_pull_up = pull_up;
            endcase
        end
    end

    // registers; all selects clear on reset
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            first_sel <= SELECT_RESET;
            second_sel <= SELECT_RESET;
            third_sel <= SELECT_RESET;
            fourth_sel <= SELECT_RESET;
            open_drain <= SELECT_RESET;
            pull_up <= SELECT_RESET;
            waitreq <= 1'b1;
            rdata <= READ_ZERO;
        end
        else
        begin
            first_sel <= next_first_sel;
            second_sel <= next_second_sel;
            third_sel <= next_third_sel;
            fourth_sel <= next_fourth_sel;
            open_drain <= next_open_drain;
            pull_up <= next_pull_up;
            waitreq <= next_waitreq;
            rdata <= next_rdata;
        end
    end

    assign O_AVS_WAITREQUEST = waitreq;
    assign O_AVS_READDATA = rdata;

    // ************************************************************
    // pin routing
    // ************************************************************
    assign cfg.first_sel = first_sel;
    assign cfg.second_sel = second_sel;
    assign cfg.third_sel = third_sel;
    assign cfg.fourth_sel = fourth_sel;
    assign cfg.open_drain = open_drain;
    assign cfg.pull_up = pull_up;

    pin_route u_route (
        .cfg(cfg.route),
        .i_port_data(I_PORT_DATA),
        .i_port_oe(I_PORT_OE),
        .i_transmit(I_SERIAL_ONE_TRANSMIT),
        .i_clock_out(I_SERIAL_ONE_CLOCK),
        .i_clock_oe(I_SERIAL_ONE_CLOCK_OE),
        .i_bus_address(I_BUS_ADDRESS),
        .i_timer_out(I_TIMER_ZERO_OUTPUT),
        .i_pin_sync(pin_sync),
        .o_pin(route_pin),
        .o_pin_oe(route_oe),
        .o_receive(route_rx),
        .o_clock_in(route_clk),
        .o_capture_a(route_cap_a),
        .o_capture_b(route_cap_b),
        .o_clear_to_send(route_cts)
    );

    // ************************************************************
    // pin synchroniser and output flops
    // ************************************************************
    // pin levels are asynchronous; two flops before any use
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            O_PIN <= 3'h0;
            O_PIN_OE <= 3'h0;
            O_PULL_UP <= 3'h0;
            O_PORT_IN <= 3'h0;
            O_SERIAL_ONE_RECEIVE <= RECEIVE_IDLE;
            O_SERIAL_ONE_CLOCK_IN <= CLOCK_IN_IDLE;
            O_TIMER_TWO_CAPTURE_IN_A <= CAPTURE_IDLE;
            O_TIMER_TWO_CAPTURE_IN_B <= CAPTURE_IDLE;
            O_SERIAL_ONE_CLEAR_TO_SEND <= CLEAR_TO_SEND_IDLE;
        end
        else
        begin
            pin_meta <= I_PIN;
            pin_sync <= pin_meta;
            O_PIN <= route_pin;
            O_PIN_OE <= route_oe;
            O_PULL_UP <= pull_up;
            O_PORT_IN <= pin_sync;
            O_SERIAL_ONE_RECEIVE <= route_rx;
            O_SERIAL_ONE_CLOCK_IN <= route_clk;
            O_TIMER_TWO_CAPTURE_IN_A <= route_cap_a;
            O_TIMER_TWO_CAPTURE_IN_B <= route_cap_b;
            O_SERIAL_ONE_CLEAR_TO_SEND <= route_cts;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);

    a_bus_answer_one: assert property ((I_AVS_READ || I_AVS_WRITE) && waitreq
        |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
        else $error("bus answer not after one stall cycle");
    a_address_readback: assert property (wr_take
        && I_AVS_ADDRESS == SECOND_ALT_FUNCTION_SELECT_OFS
        |=> second_sel == $past(I_AVS_WRITEDATA[2:0]))
        else $error("address select write lost");
    a_upper_bits_zero: assert property (I_AVS_READ && !O_AVS_WAITREQUEST
        |-> O_AVS_READDATA[31:3] == 29'h0)
        else $error("upper read bits not zero");
    a_address_route: assert property (second_sel[2] && !first_sel[2] && !open_drain[2]
        |=> O_PIN[2] == $past(I_BUS_ADDRESS[0]) && O_PIN_OE[2])
        else $error("address 0 not on pin 2");
    a_capture_route: assert property (third_sel[0] && !first_sel[0] && !second_sel[0]
        |=> !O_PIN_OE[0] && O_TIMER_TWO_CAPTURE_IN_A == $past(pin_sync[0]))
        else $error("capture a not routed");
    a_flow_mask: assert property (fourth_sel[1:0] == 2'h0
        and (fourth_sel[2] |=> O_SERIAL_ONE_CLEAR_TO_SEND == $past(pin_sync[2])))
        else $error("flow control select wrong");
    a_drain_low_only: assert property (open_drain[0] |=> O_PIN[0] == 1'b0)
        else $error("open drain pin driven high");
    a_transmit_route: assert property (first_sel[0] && !open_drain[0]
        |=> O_PIN[0] == $past(I_SERIAL_ONE_TRANSMIT) && O_PIN_OE[0])
        else $error("transmit not on pin 0");
    a_pull_follow: assert property (##1 O_PULL_UP == $past(pull_up))
        else $error("pull-up output stale");
    a_reset_clear: assert property (@(posedge I_CLK) disable iff (1'b0) !I_NRST
        |=> {first_sel, second_sel, third_sel, fourth_sel, open_drain, pull_up} == 18'h0)
        else $error("selects not cleared by reset");

    c_write_taken: cover property (wr_take);
    c_address_mode: cover property (second_sel != 3'h0);
    c_drain_mode: cover property (open_drain[2] && O_PIN_OE[2]);
    c_flow_mode: cover property (fourth_sel[2]);

endmodule

// *** testbench/three_pin_port_function_select_test.sv ***
module three_pin_port_function_select_test
    import pin_select_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus table and bench signals
    // ****************************************
    // one register fully set, pin levels applied, port and peripheral results expected
    typedef struct packed
    {
        logic [7:0] ofs;     // register written with all ones
        logic [31:0] rexp;   // value read back
        logic [2:0] pin_in;  // pin levels applied
        logic [2:0] exp_pin; // expected pin outputs
        logic [2:0] mask;    // pins whose output value matters
        logic [2:0] exp_oe;  // expected output enables
        logic [2:0] exp_pu;  // expected pull-ups
        logic [4:0] exp_per; // receive, clock in, capture a, capture b, clear to send
    } row_s;

    row_s rows [6];
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] pin_in = 3'h7;
    logic [2:0] bus_address = 3'h1; // address lines offered to pins 2..0
    logic timer_out = 1'h1;         // timer output offered to pin 2
    logic [2:0] pin_out;
    logic [2:0] pin_oe;
    logic [2:0] pull_up;
    logic [2:0] port_in;
    logic receive, clock_in, capture_a, capture_b, clear_to_send;
    logic [31:0] rd;
    int n_errors = 0;
    int total_checks = 0;

    // ****************************************
    // clock and device
    // ****************************************
    // 250 MHz clock
    initial
    begin
        forever #2 clk = ~clk;
    end

    // most port side inputs stay fixed; address and timer lines are driven
    pin_function_select i_dut (
        .I_CLK(clk), .I_NRST(nrst), .I_AVS_ADDRESS(avs_address), .I_AVS_READ(avs_read),
        .I_AVS_WRITE(avs_write), .I_AVS_WRITEDATA(avs_writedata),
        .I_AVS_BYTEENABLE(avs_byteenable), .O_AVS_READDATA(avs_readdata),
        .O_AVS_WAITREQUEST(avs_waitrequest), .I_PORT_DATA(3'h2), .I_PORT_OE(3'h7),
        .I_SERIAL_ONE_TRANSMIT(1'h1), .I_SERIAL_ONE_CLOCK(1'h0),
        .I_SERIAL_ONE_CLOCK_OE(1'h1), .I_BUS_ADDRESS(bus_address),
        .I_TIMER_ZERO_OUTPUT(timer_out),
        .I_PIN(pin_in), .O_PIN(pin_out), .O_PIN_OE(pin_oe), .O_PULL_UP(pull_up),
        .O_PORT_IN(port_in), .O_SERIAL_ONE_RECEIVE(receive),
        .O_SERIAL_ONE_CLOCK_IN(clock_in), .O_TIMER_TWO_CAPTURE_IN_A(capture_a),
        .O_TIMER_TWO_CAPTURE_IN_B(capture_b), .O_SERIAL_ONE_CLEAR_TO_SEND(clear_to_send)
    );

    // ****************************************
    // shared tasks
    // ****************************************
    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // report counts and end the run
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // one bus access: held until waitrequest is low at a rising edge, released after it
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        // levels read right after an edge are the ones the device sampled there
        do
        begin
            @(posedge clk);
        end
        while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        // a write answer carries no read data
        if (wr)
            check(avs_readdata, READ_ZERO);
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask

    // pin path settles within three edges; give it four
    task automatic settle(input logic [2:0] p);
        pin_in <= p;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    // ****************************************
    // watchdog
    // ****************************************
    // all tests need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rows[0] = '{SECOND_ALT_FUNCTION_SELECT_OFS, 32'h0000_0007, 3'h7, 3'h4, 3'h7, 3'h7,
                    3'h0, 5'h19};
        rows[1] = '{THIRD_ALT_FUNCTION_SELECT_OFS, 32'h0000_0007, 3'h3, 3'h4, 3'h4, 3'h4,
                    3'h0, 5'h1F};
        rows[2] = '{FOURTH_ALT_FUNCTION_SELECT_OFS, 32'h0000_0004, 3'h0, 3'h2, 3'h3, 3'h3,
                    3'h0, 5'h18};
        rows[3] = '{OPEN_DRAIN_SELECT_OFS, 32'h0000_0007, 3'h7, 3'h0, 3'h7, 3'h5,
                    3'h0, 5'h19};
        rows[4] = '{FIRST_ALT_FUNCTION_SELECT_OFS, 32'h0000_0007, 3'h1, 3'h1, 3'h5, 3'h5,
                    3'h0, 5'h01};
        rows[5] = '{PULL_UP_SELECT_OFS, 32'h0000_0007, 3'h7, 3'h2, 3'h7, 3'h7,
                    3'h7, 5'h19};
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        // every register starts cleared
        foreach (rows[i])
        begin
            bus(rows[i].ofs, 1'h0, 32'h0000_0000, 4'hF, rd);
            check(rd, 32'h0000_0000);
        end
        // one select register at a time, then cleared again
        foreach (rows[i])
        begin
            bus(rows[i].ofs, 1'h1, 32'hFFFF_FFFF, 4'hF, rd);
            bus(rows[i].ofs, 1'h0, 32'h0000_0000, 4'hF, rd);
            check(rd, rows[i].rexp);
            settle(rows[i].pin_in);
            check(32'(pin_out & rows[i].mask), 32'(rows[i].exp_pin));
            check(32'(pin_oe), 32'(rows[i].exp_oe));
            check(32'(pull_up), 32'(rows[i].exp_pu));
            check(32'({receive, clock_in, capture_a, capture_b, clear_to_send}),
                  32'(rows[i].exp_per));
            check(32'(port_in), 32'(rows[i].pin_in));
            bus(rows[i].ofs, 1'h1, 32'h0000_0000, 4'hF, rd);
        end
        // unmapped place: write ignored, read zero, no register disturbed
        bus(8'h18, 1'h1, 32'hFFFF_FFFF, 4'hF, rd);
        bus(8'h18, 1'h0, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        // write with low byte lane disabled leaves the register clear
        bus(SECOND_ALT_FUNCTION_SELECT_OFS, 1'h1, 32'h0000_0007, 4'hE, rd);
        bus(SECOND_ALT_FUNCTION_SELECT_OFS, 1'h0, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        // back-to-back writes: address lines through open-drain drivers
        bus(SECOND_ALT_FUNCTION_SELECT_OFS, 1'h1, 32'h0000_0007, 4'hF, rd);
        bus(OPEN_DRAIN_SELECT_OFS, 1'h1, 32'h0000_0007, 4'hF, rd);
        bus(PULL_UP_SELECT_OFS, 1'h1, 32'h0000_0005, 4'hF, rd);
        settle(3'h7);
        check(32'(pin_out), 32'h0000_0000);
        check(32'(pin_oe), 32'h0000_0003);
        check(32'(pull_up), 32'h0000_0005);
        // new address levels: pin n follows line 2-n, open drain pulls only low
        @(posedge clk);
        bus_address <= 3'h6;
        settle(3'h7);
        check(32'({pin_out, pin_oe}), 32'h0000_0004);
        // reset in mid-run clears the selects and pin enables and raises waitrequest
        @(posedge clk);
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(32'({pin_oe, pull_up, avs_waitrequest}), 32'h0000_0001);
        @(posedge clk);
        nrst <= 1'h1;
        bus(SECOND_ALT_FUNCTION_SELECT_OFS, 1'h0, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        bus(OPEN_DRAIN_SELECT_OFS, 1'h0, 32'h0000_0000, 4'hF, rd);
        check(rd, 32'h0000_0000);
        settle(3'h7);
        check(32'({pin_out, pin_oe, pull_up}), 32'h0000_00B8);
        // timer output on pin 2 follows its source
        bus(THIRD_ALT_FUNCTION_SELECT_OFS, 1'h1, 32'h0000_0004, 4'hF, rd);
        timer_out <= 1'h0;
        settle(3'h7);
        check(32'({pin_out, pin_oe}), 32'h0000_0017);
        print_verdict();
    end
endmodule
